// [design/dla_pkg.sv]
// Shared constants for the DPLL lock-assist block and its steerable fractional dividers.
// Assumes one 100 MHz clock (mclk) and software access over Avalon-MM.
package dla_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_MHZ       = 100;
   localparam int MS_PER_TICK   = 1;
   localparam int MS_CYCLES     = MS_PER_TICK * CLK_MHZ * 1000;
   // ==========================================================
   // Register map: word indices inside one channel (byte offset is index times 4), channel stride 0x40
   localparam logic [7:0] CHAN_STRIDE = 8'h40;
   localparam logic [3:0] R_CTRL     = 4'h0;
   localparam logic [3:0] R_PSL      = 4'h1;
   localparam logic [3:0] R_MAXOFF   = 4'h2;
   localparam logic [3:0] R_FSL      = 4'h3;
   localparam logic [3:0] R_ACQPSL   = 4'h4;
   localparam logic [3:0] R_BW       = 4'h5;
   localparam logic [3:0] R_DIVINT   = 4'h6;
   localparam logic [3:0] R_FRACLO   = 4'h7;
   localparam logic [3:0] R_FRACHI   = 4'h8;
   localparam logic [3:0] R_FINEADJ  = 4'h9;
   localparam logic [3:0] R_FINERATE = 4'ha;
   localparam logic [3:0] R_STATUS   = 4'hb;
   localparam int         NREG       = 12;
   // ==========================================================
   // Field positions in CTRL
   localparam int B_PSL_EN   = 0;
   localparam int B_FSL_EN   = 1;
   localparam int B_ACQ_EN   = 4;   // [7:4] fsnap, psnap, pullin, wide
   localparam int B_PREACQ   = 8;
   localparam int B_REC_EN   = 12;  // [15:12] fsnap, psnap, pullin, wide
   localparam int B_WIDE_SEL = 16;  // [18:16] bandwidth, slope limit, damping
   // ==========================================================
   // Reset values
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] PSL_RST    = 32'h0000_1d4b;  // 7500 ns/s
   localparam logic [31:0] MAXOFF_RST = 32'h0000_2710;  // 10000 ppb
   localparam logic [31:0] DIVINT_RST = 32'h0000_0014;  // ratio 20
   localparam logic [7:0]  BW_MAX     = 8'hff;
   // ==========================================================
   // Divider arithmetic
   localparam logic [48:0] PHASE_UNIT   = 49'h0_0800_0000_0000; // 2^43
   localparam logic [17:0] PPB_TO_FRAC  = 18'h2_af32;         // frac units per ppb at ratio 20
   localparam logic [35:0] DFRAC_PER_PS = 36'h4_1893_74bc;     // ratio change per ps per cycle
   localparam logic [7:0]  FINE_PS_SLOW = 8'h01;
   localparam logic [7:0]  FINE_PS_MED  = 8'h04;
   localparam logic [7:0]  FINE_PS_FAST = 8'h10;
   // ==========================================================
   // Enumerations
   typedef enum logic [2:0] {
      LS_FREERUN  = 3'h0,
      LS_ACQUIRE  = 3'h1,
      LS_RECOVER  = 3'h2,
      LS_LOCKED   = 3'h3,
      LS_HOLDOVER = 3'h4
   } dla_lock_e;
   typedef enum logic [2:0] {
      FL_IDLE   = 3'h0,
      FL_FSNAP  = 3'h1,
      FL_PSNAP  = 3'h2,
      FL_PULLIN = 3'h3,
      FL_PREACQ = 3'h4,
      FL_WIDE   = 3'h5,
      FL_HOLD   = 3'h6
   } dla_fl_e;

   function automatic logic [7:0] fine_step_ps(input logic [1:0] rate);
      case (rate)
         2'h0:    fine_step_ps = FINE_PS_SLOW;
         2'h1:    fine_step_ps = FINE_PS_MED;
         default: fine_step_ps = FINE_PS_FAST;
      endcase
   endfunction
endpackage

// [design/dla_frac_div.sv]
// Steerable fractional divider: output rate is mclk / (int + frac / 2^43).
// Assumes steer and fine-adjust inputs synchronous to mclk.
`timescale 1ns/1ps
module dla_frac_div import dla_pkg::*; (
   input  wire logic               mclk,
   input  wire logic               resetn,
   input  wire logic [4:0]         div_int,
   input  wire logic [42:0]        div_frac,
   input  wire logic signed [43:0] steer_frac,
   input  wire logic               fine_load,
   input  wire logic signed [31:0] fine_ps,
   input  wire logic [1:0]         fine_rate,
   output logic                    div_tick,
   output logic                    fine_busy,
   output logic [47:0]             ratio_eff
);
   logic signed [39:0] remain_reg, remain_next;
   logic [48:0]        phase_reg, phase_next;
   logic [47:0]        ratio_reg, ratio_next;
   logic               tick_reg, tick_next;
   logic signed [39:0] step;
   logic signed [49:0] fdelta, sum;

   always_comb begin
      step        = 40'(fine_step_ps(fine_rate));
      fdelta      = 50'(step * $signed({1'b0, DFRAC_PER_PS}));
      remain_next = remain_reg;
      // Edges move only while phase is still owed, then the ratio returns to nominal
      if (remain_reg > step)
         remain_next = remain_reg - step;
      else if (remain_reg < -step)
         remain_next = remain_reg + step;
      else
         remain_next = 40'sh0;
      if (fine_load)
         remain_next = remain_next + 40'(fine_ps);
      sum = $signed({2'b00, div_int, div_frac}) + 50'(steer_frac);
      // Delay means a longer ratio (lower frequency), advance a shorter one
      if (remain_reg > 0)
         sum = sum + fdelta;
      else if (remain_reg < 0)
         sum = sum - fdelta;
      ratio_next = sum[47:0];
      phase_next = phase_reg + PHASE_UNIT;
      tick_next  = 1'b0;
      if (phase_next >= {1'b0, ratio_reg}) begin
         phase_next = phase_next - {1'b0, ratio_reg};
         tick_next  = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         remain_reg <= 40'sh0;
         phase_reg  <= 49'h0;
         ratio_reg  <= 48'h0;
         tick_reg   <= 1'b0;
      end else begin
         remain_reg <= remain_next;
         phase_reg  <= phase_next;
         ratio_reg  <= ratio_next;
         tick_reg   <= tick_next;
      end
   end

   assign div_tick  = tick_reg;
   assign fine_busy = (remain_reg != 40'sh0);
   assign ratio_eff = ratio_reg;
endmodule

// [design/dla_lock_assist.sv]
// DPLL lock assist for two channels, each owning one steerable fractional divider.
// Assumes loop filter, phase detector and lock state come from the DPLL core on mclk.
//
// How it works
// - Each channel has its own slope limiter enable and slope setting.
// - Slope limit is setting plus one, in ns/s, 1 to 65536.
// - Enabled limiter caps output frequency deviation from reference to the slope.
// - With limiter off only the loop filter shapes the slope.
// - 61000, 7500 and 885 ns/s are all legal settings.
// - Frequency is clamped to the channel maximum offset in every state.
// - Four fast-lock options, separately enabled for acquire and recover.
// - Precedence freq snap, phase snap, pull-in, wide; only one runs.
// - Frequency snap loads measured reference offset straight into the divider.
// - Frequency snap may ramp at the programmed frequency slope per ms.
// - Phase snap pulses a phase load; pull-in isolates detector and filter.
// - Wide mode applies selected relaxed settings until lock, then restores.
// - Acquire only: maximum bandwidth for programmed ms, temporary slope kept.
// - Pre-acquisition runs before wide bandwidth.
// - Divider rate is mclk over int plus frac over 2^43.
// - Signed ps write delays (positive) or advances (negative) edges.
// - Fast, medium or slow rate sets frequency change size and duration.
// - Fine adjustments accumulate in a 40-bit signed remainder that wraps on overflow.
// - Divider five feeds stages 4, 5; six feeds 6, 7; both feed feedback.
`timescale 1ns/1ps
module dla_lock_assist import dla_pkg::*; #(
   parameter int MS_CYC = MS_CYCLES
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic [7:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   output logic [31:0]           avs_readdata,
   output logic                  avs_waitrequest,
   input  wire logic [1:0][2:0]  lock_state,
   input  wire logic [1:0]       loop_locked,
   input  wire logic [1:0][31:0] loop_freq_ppb,
   input  wire logic [1:0][31:0] ref_freq_ppb,
   output logic [1:0]            phase_snap_load,
   output logic [1:0]            loop_isolate,
   output logic [1:0][7:0]       loop_bw_code,
   output logic [1:0]            damping_relax,
   output logic [1:0]            feedback_tick,
   output logic [3:0]            stage_tick
);
   // ==========================================================
   // Shared helpers
   function automatic logic signed [31:0] clamp32(input logic signed [33:0] v,
                                                  input logic signed [33:0] lo,
                                                  input logic signed [33:0] hi);
      if (v < lo)
         clamp32 = 32'(lo);
      else if (v > hi)
         clamp32 = 32'(hi);
      else
         clamp32 = 32'(v);
   endfunction

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a[7] == 1'b0) && (a[5:2] < 4'(NREG)) && (a[1:0] == 2'b00);
   endfunction

   // ==========================================================
   // Avalon-MM slave: one wait cycle, then the access completes
   logic [31:0]      cfg_reg  [2][NREG];
   logic [31:0]      cfg_next [2][NREG];
   logic             ack_reg, ack_next;
   logic [31:0]      rdata_reg, rdata_next;
   logic             wr_go;
   logic             chan;
   logic [3:0]       idx;
   logic [2:0]       st_q      [2];
   logic [1:0]       fine_busy;
   logic [1:0]       clamp_evt;
   logic [1:0]       clamp_sticky_reg, clamp_sticky_next;
   logic [1:0]       fine_load;
   logic [1:0]       div_tick;

   assign chan            = avs_address[6];
   assign idx             = avs_address[5:2];
   assign wr_go           = avs_write && ack_reg && reg_hit(avs_address);
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign avs_readdata    = rdata_reg;

   always_comb begin
      ack_next          = (avs_read || avs_write) && !ack_reg;
      rdata_next        = rdata_reg;
      clamp_sticky_next = clamp_sticky_reg;
      cfg_next          = cfg_reg;
      fine_load         = 2'b00;
      if (avs_read && !ack_reg) begin
         rdata_next = 32'h0;
         if (reg_hit(avs_address)) begin
            case (idx)
               R_STATUS:  rdata_next = {27'h0, clamp_sticky_reg[chan], fine_busy[chan],
                                        st_q[chan]};
               default:   rdata_next = cfg_reg[chan][idx];
            endcase
         end
      end
      if (wr_go) begin
         case (idx)
            R_FINEADJ: fine_load[chan] = 1'b1;
            R_STATUS:  clamp_sticky_next[chan] = clamp_sticky_reg[chan] & ~avs_writedata[4];
            default:   cfg_next[chan][idx] = avs_writedata;
         endcase
      end
      // A clamp in the same cycle as its clear keeps the flag set
      clamp_sticky_next = clamp_sticky_next | clamp_evt;
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ack_reg          <= 1'b0;
         rdata_reg        <= 32'h0;
         clamp_sticky_reg <= 2'b00;
         for (int c = 0; c < 2; c++) begin
            for (int r = 0; r < NREG; r++) begin
               cfg_reg[c][r] <= 32'h0;
            end
            cfg_reg[c][R_PSL]    <= PSL_RST;
            cfg_reg[c][R_MAXOFF] <= MAXOFF_RST;
            cfg_reg[c][R_DIVINT] <= DIVINT_RST;
            cfg_reg[c][R_CTRL]   <= CTRL_RST;
         end
      end else begin
         ack_reg          <= ack_next;
         rdata_reg        <= rdata_next;
         clamp_sticky_reg <= clamp_sticky_next;
         cfg_reg          <= cfg_next;
      end
   end

   // ==========================================================
   // Millisecond tick for snap ramps; pre-acquisition counts MS_CYC cycles per ms itself
   logic [31:0] ms_cnt_reg, ms_cnt_next;
   logic        ms_tick;

   assign ms_tick = (ms_cnt_reg == 32'(MS_CYC - 1));

   always_comb begin
      ms_cnt_next = ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
   end

   always_ff @(posedge mclk) begin
      if (!resetn)
         ms_cnt_reg <= 32'h0;
      else
         ms_cnt_reg <= ms_cnt_next;
   end

   // ==========================================================
   // Per-channel fast-lock sequencer, frequency limiter and divider
   for (genvar c = 0; c < 2; c++) begin : g_ch
      dla_fl_e             st_reg, st_next;
      logic signed [31:0]  snap_reg, snap_next;
      logic signed [31:0]  freq_reg, freq_next;
      logic [31:0]         pre_reg, pre_next;
      logic [7:0]          bw_reg, bw_next;
      logic                iso_reg, iso_next;
      logic                psnap_reg, psnap_next;
      logic                damp_reg, damp_next;
      logic [31:0]         ctrl;
      logic [3:0]          en;
      logic                acq, active, slope_tmp;
      logic signed [33:0]  lim, maxo, refv, want, step;
      logic signed [31:0]  snap_tgt, limited;
      logic signed [50:0]  prod;
      logic signed [43:0]  steer;

      assign ctrl = cfg_reg[c][R_CTRL];
      assign acq  = (lock_state[c] == LS_ACQUIRE);

      always_comb begin
         active     = acq || (lock_state[c] == LS_RECOVER);
         en         = acq ? ctrl[B_ACQ_EN +: 4] : ctrl[B_REC_EN +: 4];
         st_next    = st_reg;
         snap_next  = snap_reg;
         pre_next   = pre_reg;
         psnap_next = 1'b0;
         maxo       = {3'b000, cfg_reg[c][R_MAXOFF][30:0]};
         refv       = 34'($signed(ref_freq_ppb[c]));
         snap_tgt   = clamp32(refv, -maxo, maxo);
         step       = {18'h0, cfg_reg[c][R_FSL][15:0]};
         case (st_reg)
            FL_IDLE: begin
               if (active) begin
                  if (en[0])
                     st_next = FL_FSNAP;
                  else if (en[1])
                     st_next = FL_PSNAP;
                  else if (en[2])
                     st_next = FL_PULLIN;
                  else if (acq && ctrl[B_PREACQ])
                     st_next = FL_PREACQ;
                  else if (en[3])
                     st_next = FL_WIDE;
                  else
                     st_next = FL_HOLD;
                  snap_next  = freq_reg;
                  pre_next   = 32'h0;
                  psnap_next = !en[0] && en[1];
               end
            end
            FL_FSNAP: begin
               // Without the slope option the target lands in one step
               if (!ctrl[B_FSL_EN])
                  snap_next = snap_tgt;
               else if (ms_tick) begin
                  snap_next = clamp32(34'(snap_tgt), 34'(snap_reg) - step,
                                      34'(snap_reg) + step);
               end
               if (snap_reg == snap_tgt)
                  st_next = FL_HOLD;
            end
            FL_PSNAP:  st_next = FL_HOLD;
            FL_PULLIN: if (loop_locked[c]) st_next = FL_HOLD;
            FL_PREACQ: begin
               pre_next = pre_reg + 32'h1;
               if (pre_reg >= 32'(cfg_reg[c][R_FSL][31:16] * MS_CYC))
                  st_next = en[3] ? FL_WIDE : FL_HOLD;
            end
            FL_WIDE:   if (loop_locked[c]) st_next = FL_HOLD;
            FL_HOLD:   st_next = FL_HOLD;
            default:   st_next = FL_IDLE;
         endcase
         if (!active)
            st_next = FL_IDLE;

         // Temporary slope limit holds through pre-acquisition, and through wide mode when its slope bit is selected
         slope_tmp = (st_reg == FL_PREACQ) ||
                     ((st_reg == FL_WIDE) && ctrl[B_WIDE_SEL + 1]);
         lim  = slope_tmp ? {17'h0, cfg_reg[c][R_ACQPSL][15:0]} + 34'sh1
                          : {17'h0, cfg_reg[c][R_PSL][15:0]} + 34'sh1;
         want = 34'($signed(loop_freq_ppb[c]));
         if (ctrl[B_PSL_EN])
            limited = clamp32(want, refv - lim, refv + lim);
         else
            limited = 32'(want);
         if (st_reg == FL_FSNAP)
            limited = snap_reg;
         freq_next = clamp32(34'(limited), -maxo, maxo);
         clamp_evt[c] = (34'(limited) > maxo) || (34'(limited) < -maxo);

         iso_next  = (st_next == FL_PULLIN);
         damp_next = (st_next == FL_WIDE) && ctrl[B_WIDE_SEL + 2];
         if (st_next == FL_PREACQ)
            bw_next = BW_MAX;
         else if ((st_next == FL_WIDE) && ctrl[B_WIDE_SEL])
            bw_next = cfg_reg[c][R_BW][7:0];
         else
            bw_next = cfg_reg[c][R_BW][15:8];
      end

      always_ff @(posedge mclk) begin
         if (!resetn) begin
            st_reg    <= FL_IDLE;
            snap_reg  <= 32'sh0;
            freq_reg  <= 32'sh0;
            pre_reg   <= 32'h0;
            bw_reg    <= 8'h00;
            iso_reg   <= 1'b0;
            psnap_reg <= 1'b0;
            damp_reg  <= 1'b0;
         end else begin
            st_reg    <= st_next;
            snap_reg  <= snap_next;
            freq_reg  <= freq_next;
            pre_reg   <= pre_next;
            bw_reg    <= bw_next;
            iso_reg   <= iso_next;
            psnap_reg <= psnap_next;
            damp_reg  <= damp_next;
         end
      end

      // Higher frequency means a shorter divide ratio
      assign prod  = -(51'(freq_reg) * $signed({1'b0, PPB_TO_FRAC}));
      assign steer = prod[43:0];
      assign st_q[c]            = st_reg;
      assign loop_bw_code[c]    = bw_reg;
      assign loop_isolate[c]    = iso_reg;
      assign phase_snap_load[c] = psnap_reg;
      assign damping_relax[c]   = damp_reg;

      dla_frac_div u_div (
         .mclk       (mclk),
         .resetn     (resetn),
         .div_int    (cfg_reg[c][R_DIVINT][4:0]),
         .div_frac   ({cfg_reg[c][R_FRACHI][10:0], cfg_reg[c][R_FRACLO]}),
         .steer_frac (steer),
         .fine_load  (fine_load[c]),
         .fine_ps    (avs_writedata),
         .fine_rate  (cfg_reg[c][R_FINERATE][1:0]),
         .div_tick   (div_tick[c]),
         .fine_busy  (fine_busy[c]),
         .ratio_eff  ()
      );
   end

   // ==========================================================
   // Fixed fan-out: divider five to stages 4 and 5, six to 6 and 7
   assign feedback_tick = div_tick;
   assign stage_tick    = {div_tick[1], div_tick[1], div_tick[0], div_tick[0]};
endmodule

// [test/dla_lock_assist_props.sv]
// Concurrent checks on the lock-assist top-level ports.
// Assumes one clock domain: mclk with synchronous active-low resetn.
`timescale 1ns/1ps
module dla_lock_assist_props import dla_pkg::*; #(
   parameter int MS_CYC = MS_CYCLES
) (
   input wire logic             mclk,
   input wire logic             resetn,
   input wire logic [7:0]       avs_address,
   input wire logic             avs_read,
   input wire logic             avs_write,
   input wire logic [31:0]      avs_writedata,
   input wire logic [31:0]      avs_readdata,
   input wire logic             avs_waitrequest,
   input wire logic [1:0][2:0]  lock_state,
   input wire logic [1:0]       loop_locked,
   input wire logic [1:0][31:0] loop_freq_ppb,
   input wire logic [1:0][31:0] ref_freq_ppb,
   input wire logic [1:0]       phase_snap_load,
   input wire logic [1:0]       loop_isolate,
   input wire logic [1:0][7:0]  loop_bw_code,
   input wire logic [1:0]       damping_relax,
   input wire logic [1:0]       feedback_tick,
   input wire logic [3:0]       stage_tick
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // Divider output and routing
   tick_gap_five_a: assert property (feedback_tick[0] |=> !feedback_tick[0] [*8])
      else $error("divider five ticks too close");
   tick_gap_six_a: assert property (feedback_tick[1] |=> !feedback_tick[1] [*8])
      else $error("divider six ticks too close");
   stage_route_a: assert property (stage_tick == {{2{feedback_tick[1]}}, {2{feedback_tick[0]}}})
      else $error("stage tick misrouted");
   // ==========================================================
   // Fast-lock outputs
   snap_pulse_a: assert property (phase_snap_load[0] |=> !phase_snap_load[0])
      else $error("phase snap too long");
   snap_excl_a: assert property (!(phase_snap_load[0] && loop_isolate[0]))
      else $error("phase snap and pull-in together");
   isolate_cause_a: assert property ($rose(loop_isolate[0]) |->
      $past(lock_state[0]) == 3'h1 || $past(lock_state[0]) == 3'h2)
      else $error("pull-in outside acquire");
   isolate_end_a: assert property (loop_locked[0] && loop_isolate[0] |-> ##[1:2] !loop_isolate[0])
      else $error("pull-in kept after lock");
   wide_end_a: assert property (loop_locked[0] && damping_relax[0] |-> ##[1:2] !damping_relax[0])
      else $error("damping kept after lock");
   quiet_a: assert property ((lock_state[0] == 3'h3) [*3] |->
      !loop_isolate[0] && !damping_relax[0] && !phase_snap_load[0])
      else $error("fast lock active while locked");
endmodule

bind dla_lock_assist dla_lock_assist_props #(.MS_CYC(MS_CYC)) u_props (.mclk, .resetn,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
   .lock_state, .loop_locked, .loop_freq_ppb, .ref_freq_ppb, .phase_snap_load, .loop_isolate,
   .loop_bw_code, .damping_relax, .feedback_tick, .stage_tick);

// [test/dla_stage_model.sv]
// Far side: output stages and feedback dividers counting divider ticks.
// Assumes ticks are one-cycle pulses on mclk.
`timescale 1ns/1ps
module dla_stage_model (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic [1:0]       feedback_tick,
   input  wire logic [3:0]       stage_tick,
   output logic      [1:0][15:0] fb_cnt,
   output logic      [3:0][15:0] st_cnt
);
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         fb_cnt <= '0;
         st_cnt <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            fb_cnt[i] <= fb_cnt[i] + 16'(feedback_tick[i]);
         end
         for (int i = 0; i < 4; i++) begin
            st_cnt[i] <= st_cnt[i] + 16'(stage_tick[i]);
         end
      end
   end
endmodule

// [test/dla_lock_assist_test.sv]
// Self-checking bench for the lock-assist block with a register model.
// Assumes the design, its package and the far-side stage model.
`timescale 1ns/1ps
module dla_lock_assist_test import dla_pkg::*;;
   logic             mclk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [7:0]       avs_address;
   logic [31:0]      avs_writedata, avs_readdata, q;
   logic [1:0][2:0]  lock_state;
   logic [1:0]       loop_locked, phase_snap_load, loop_isolate, damping_relax, feedback_tick;
   logic [1:0][31:0] loop_freq_ppb, ref_freq_ppb;
   logic [1:0][7:0]  loop_bw_code;
   logic [3:0]       stage_tick;
   logic [1:0][15:0] fb_cnt;
   logic [3:0][15:0] st_cnt;
   logic [31:0]      mdl [32];
   int               miscompares, samples_checked, n;
   int               wl [8] = '{1, 2, 3, 4, 5, 7, 8, 10};
   dla_lock_assist #(.MS_CYC(10)) dut (.mclk, .resetn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .lock_state, .loop_locked,
      .loop_freq_ppb, .ref_freq_ppb, .phase_snap_load, .loop_isolate, .loop_bw_code,
      .damping_relax, .feedback_tick, .stage_tick);
   dla_stage_model far (.mclk, .resetn, .feedback_tick, .stage_tick, .fb_cnt, .st_cnt);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   function automatic logic [31:0] msk(input int r);
      case (r)
         0: msk = 32'h0007_f1f3;
         1, 4, 5: msk = 32'h0000_ffff;
         2: msk = 32'h7fff_ffff;
         3, 7: msk = 32'hffff_ffff;
         6: msk = 32'h0000_001f;
         8: msk = 32'h0000_07ff;
         10: msk = 32'h0000_0003;
         default: msk = 32'h0;
      endcase
   endfunction
   // Held until waitrequest low, then one idle edge
   task automatic bus(input logic w, input int c, input int r, input logic [31:0] d);
      int k;
      k = 0;
      avs_address <= {1'b0, c[0], r[3:0], 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
         @(posedge mclk);
         k++;
      end
      chk(32'(k < 50), 32'h1, "bus answer");
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input int c, input int r, input logic [31:0] d);
      bus(1'b1, c, r, d);
      mdl[c*16+r] = d & msk(r);
   endtask
   // Fast-lock run on channel 0; e is {damping, isolate, snap}
   task automatic fl(input logic [31:0] ctrl, input logic [2:0] s, input logic [2:0] e);
      logic [2:0] v;
      logic       o;
      v = '0;
      o = 1'b0;
      wr(0, 0, ctrl);
      lock_state[0] <= s;
      repeat (20) begin
         @(posedge mclk);
         v |= {damping_relax[0], loop_isolate[0], phase_snap_load[0]};
         o |= loop_isolate[1] | damping_relax[1] | phase_snap_load[1];
      end
      loop_locked[0] <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(32'(v), 32'(e), "fast lock choice");
      chk(32'(o | loop_isolate[0] | damping_relax[0]), 32'h0, "restore");
      lock_state[0] <= LS_LOCKED;
      loop_locked[0] <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   function automatic logic [2:0] ex(input int m);
      ex = m[0] ? 3'h0 : m[1] ? 3'h1 : m[2] ? 3'h2 : m[3] ? 3'h4 : 3'h0;
   endfunction
   initial begin
      miscompares = 0;
      samples_checked = 0;
      {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {lock_state, loop_locked, loop_freq_ppb, ref_freq_ppb} = '0;
      void'($urandom(92092));
      foreach (mdl[i]) mdl[i] = '0;
      for (int c = 0; c < 2; c++) begin
         mdl[c*16+1] = PSL_RST;
         mdl[c*16+2] = MAXOFF_RST;
         mdl[c*16+6] = DIVINT_RST;
      end
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      ref_freq_ppb[1] <= 32'($urandom_range(500));
      @(posedge mclk);
      for (int i = 0; i < 32; i++) begin
         bus(1'b0, i / 16, i % 16, 32'h0);
         chk(q, (i % 16) < 12 ? mdl[i] : 32'h0, "reset value");
      end
      $display("test reset_values done");
      foreach (wl[i]) for (int c = 0; c < 2; c++)
         wr(c, wl[i], wl[i] == 6 ? 32'h10 | $urandom() & 7 : $urandom() & msk(wl[i]));
      for (int i = 0; i < 32; i++) begin
         bus(1'b0, i / 16, i % 16, 32'h0);
         chk(q, (i % 16) < 12 ? mdl[i] : 32'h0, "readback");
      end
      foreach (wl[i]) wr(0, 1, {16'h0, 16'($urandom())} | (i < 3 ? 32'hffff : 32'h0));
      $display("test registers done");
      wr(0, 2, 32'd100);
      loop_freq_ppb[0] <= 32'd5000;
      repeat (3) @(posedge mclk);
      bus(1'b0, 0, 11, 32'h0);
      chk(q & 32'h10, 32'h10, "clamp seen");
      loop_freq_ppb[0] <= 32'h0;
      wr(0, 11, 32'h10);
      bus(1'b0, 0, 11, 32'h0);
      chk(q & 32'h10, 32'h0, "clamp cleared");
      $display("test clamp done");
      for (int c = 0; c < 2; c++) begin
         wr(c, 6, 32'd16);
         wr(c, 7, 32'h0);
         wr(c, 8, 32'h400);
         wr(c, 10, 32'h0);
         n = -1;
         for (int k = 0; k < 3 && n < 200; ) begin
            @(posedge mclk);
            n++;
            if (feedback_tick[c] === 1'b1) k++;
            if (feedback_tick[c] === 1'b1 && k == 1) n = 0;
         end
         chk(32'(n), 32'd33, "ratio 16.5");
      end
      $display("test divider done");
      for (int r = 0; r < 3; r++) begin
         wr(0, 10, 32'(r));
         wr(0, 9, 32'hffff_ff80);
         bus(1'b0, 0, 11, 32'h0);
         chk(q & 32'h8, 32'h8, "fine busy");
         repeat (140) @(posedge mclk);
         bus(1'b0, 0, 11, 32'h0);
         chk(q & 32'h8, 32'h0, "fine done");
      end
      $display("test fine_adjust done");
      for (int m = 0; m < 16; m++) begin
         fl(32'h0004_0000 | (32'(m) << 4), LS_ACQUIRE, ex(m));
         fl(32'h0004_0000 | (32'(m) << 12), LS_RECOVER, ex(m));
      end
      $display("test fast_lock done");
      wr(0, 5, 32'h1234);
      wr(0, 3, 32'h0002_0000);
      wr(0, 0, 32'h0001_0180);
      lock_state[0] <= LS_ACQUIRE;
      n = 0;
      repeat (60) begin
         @(posedge mclk);
         if (loop_bw_code[0] === 8'hff) n++;
      end
      chk(32'(n >= 19 && n <= 21), 32'h1, "preacq length");
      chk(32'(loop_bw_code[0]), 32'h34, "wide after pre-acq");
      loop_locked[0] <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(32'(loop_bw_code[0]), 32'h12, "normal bandwidth");
      for (int i = 0; i < 4; i++) chk(32'(st_cnt[i]), 32'(fb_cnt[i/2]), "stage count");
      $display("test preacq_and_stages done");
      print_verdict();
   end
endmodule
